// ### src/bsc_defines.vh
`ifndef BSC_DEFINES_VH
`define BSC_DEFINES_VH

// value format: signed fixed point, one lsb = 1 fF
`define BSC_VAL_W        32
// percent format: one lsb = 0.01 %
`define BSC_PCT_W        16
`define BSC_PCT_SCALE    64'sd10000

// number of primary ranges and index of the secondary range
`define BSC_NUM_PRI      9
`define BSC_SEC_IDX      4'h9

// bound designation modes
`define BSC_MODE_ABS     2'h0
`define BSC_MODE_TOL_ABS 2'h1
`define BSC_MODE_TOL_PCT 2'h2

// sorting categories
`define BSC_CAT_W        4
`define BSC_CAT_REJECT   4'h0
`define BSC_CAT_AUX      4'hA
`define BSC_CAT_OVERLOAD_RESULT     4'hB
`define BSC_NUM_CAT      12

// counters
`define BSC_CNT_W        20
`define BSC_CNT_MAX      20'hF423F

// test frequency codes
`define BSC_FREQ_100HZ   3'h0
`define BSC_FREQ_120HZ   3'h1
`define BSC_FREQ_1KHZ    3'h2
`define BSC_FREQ_10KHZ   3'h3
`define BSC_FREQ_100KHZ  3'h4
`define BSC_FREQ_1MHZ    3'h5

// minimum range full scale for auto range, in fF
`define BSC_FS_10NF      32'sd10000000
`define BSC_FS_100PF     32'sd100000
`define BSC_FS_1PF       32'sd1000

`endif

// ### src/bsc_range_check.v
`timescale 1ns/1ps
`include "bsc_defines.vh"

// one limit range: turns stored bounds into absolute ones and tests a value
module bsc_range_check #(
    parameter W = `BSC_VAL_W
) (
    input  wire                  range_on,
    input  wire [1:0]            mode,
    input  wire signed [W-1:0]   reference_value,
    input  wire signed [W-1:0]   lo_set,
    input  wire signed [W-1:0]   hi_set,
    input  wire signed [W-1:0]   value,
    output wire                  hit,
    output wire                  improper
);
    reg signed [W-1:0]  lo_abs;
    reg signed [W-1:0]  hi_abs;
    reg signed [63:0]   lo_dev;
    reg signed [63:0]   hi_dev;

    // bounds from the reference in the two tolerance modes, stored values in absolute mode; no check that the reference lies inside
    always @* begin
        lo_dev = (reference_value * lo_set) / `BSC_PCT_SCALE;
        hi_dev = (reference_value * hi_set) / `BSC_PCT_SCALE;
        case (mode)
            `BSC_MODE_TOL_ABS: begin
                lo_abs = reference_value + lo_set;
                hi_abs = reference_value + hi_set;
            end
            `BSC_MODE_TOL_PCT: begin
                lo_abs = reference_value + lo_dev[W-1:0];
                hi_abs = reference_value + hi_dev[W-1:0];
            end
            default: begin
                lo_abs = lo_set;
                hi_abs = hi_set;
            end
        endcase
    end

    // upper at or below lower means the range is off; inclusive compare
    assign hit      = range_on && (hi_abs > lo_abs) && (value >= lo_abs) && (value <= hi_abs);
    // warning on the stored pair whether or not the range is switched on
    assign improper = (lo_set > hi_set);
endmodule

// ### src/bsc_comparator.v
`timescale 1ns/1ps
`include "bsc_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module bsc_comparator #(
    parameter W        = `BSC_VAL_W,
    parameter CHANNELS = 4,
    parameter CH_W     = 2
) (
    input  wire                     clk_sys,
    input  wire                     rst_n,
    // limit entry
    input  wire [3:0]               lim_sel,
    input  wire signed [W-1:0]      lim_value,
    input  wire                     lim_wr_lo,
    input  wire                     lim_wr_hi,
    input  wire                     lim_wr_on,
    input  wire                     lim_wr_off,
    input  wire                     lim_clear,
    input  wire                     table_clear,
    // configuration
    input  wire                     comp_enable,
    input  wire [1:0]               mode,
    input  wire signed [W-1:0]      reference_value,
    input  wire                     aux_enable,
    input  wire                     low_enable,
    input  wire [`BSC_PCT_W-1:0]    low_pct,
    input  wire                     auto_range,
    input  wire [2:0]               freq_sel,
    input  wire signed [W-1:0]      range_full_scale,
    input  wire                     multi_enable,
    // measurement
    input  wire                     meas_valid,
    input  wire signed [W-1:0]      meas_primary,
    input  wire signed [W-1:0]      meas_secondary,
    input  wire                     meas_overload,
    input  wire [CH_W-1:0]          meas_channel,
    // counting
    input  wire                     count_on_cmd,
    input  wire                     count_off_cmd,
    input  wire                     count_reset_cmd,
    input  wire [CH_W-1:0]          cnt_rd_channel,
    input  wire [`BSC_CAT_W-1:0]    cnt_rd_category,
    // results
    output reg                      result_valid,
    output reg  [`BSC_CAT_W-1:0]    category,
    output reg                      overload_result,
    output reg                      low_value_indication,
    output reg                      low_value_or_no_contact_n,
    output reg                      improper_limits,
    output reg                      counting_active,
    output reg  [`BSC_CNT_W-1:0]    cnt_rd_data
);
    localparam NR   = `BSC_NUM_PRI + 1;
    localparam NCNT = CHANNELS * `BSC_NUM_CAT;

    reg signed [W-1:0]      lo_mem [0:NR-1];
    reg signed [W-1:0]      hi_mem [0:NR-1];
    reg [NR-1:0]            range_on;
    reg [`BSC_CNT_W-1:0]    cnt_mem [0:NCNT-1];

    wire [NR-1:0]           hit;
    wire [NR-1:0]           bad;
    reg  [`BSC_CAT_W-1:0]   next_category;
    reg                     pri_pass;
    reg signed [W-1:0]      low_fs;
    reg signed [63:0]       low_prod;
    reg signed [W-1:0]      low_bound;
    reg                     next_low;
    reg [CH_W-1:0]          cnt_ch;
    integer                 i;
    integer                 cidx;

    ////////////////////////////////////////////////////////////////////////////
    // one checker per range, the secondary one always in absolute mode
    genvar g;
    generate
        for (g = 0; g < NR; g = g + 1) begin : gen_rng
            bsc_range_check #(
                .W (W)
            ) u_rng (
                .range_on        (range_on[g]),
                .mode            ((g == NR - 1) ? `BSC_MODE_ABS : mode),
                .reference_value (reference_value),
                .lo_set          (lo_mem[g]),
                .hi_set          (hi_mem[g]),
                .value           ((g == NR - 1) ? meas_secondary : meas_primary),
                .hit             (hit[g]),
                .improper        (bad[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // limit table storage and entry fix-up
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            range_on <= {NR{1'b0}};
            for (i = 0; i < NR; i = i + 1) begin
                lo_mem[i] <= {W{1'b0}};
                hi_mem[i] <= {W{1'b0}};
            end
        end else if (table_clear) begin
            range_on <= {NR{1'b0}};
            for (i = 0; i < NR; i = i + 1) begin
                lo_mem[i] <= {W{1'b0}};
                hi_mem[i] <= {W{1'b0}};
            end
        end else if (lim_sel < NR) begin
            if (lim_clear) begin
                lo_mem[lim_sel]   <= {W{1'b0}};
                hi_mem[lim_sel]   <= {W{1'b0}};
                range_on[lim_sel] <= 1'b0;
            end else if (lim_wr_lo) begin
                lo_mem[lim_sel] <= lim_value;
                hi_mem[lim_sel] <= lim_value;
            end else if (lim_wr_hi) begin
                hi_mem[lim_sel] <= lim_value;
                lo_mem[lim_sel] <= -lim_value;
            end else if (lim_wr_on) begin
                range_on[lim_sel] <= 1'b1;
            end else if (lim_wr_off) begin
                range_on[lim_sel] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // low-value boundary from the applicable full scale
    always @* begin
        if (auto_range) begin
            case (freq_sel)
                `BSC_FREQ_100HZ,
                `BSC_FREQ_120HZ: low_fs = `BSC_FS_10NF;
                `BSC_FREQ_1KHZ,
                `BSC_FREQ_10KHZ,
                `BSC_FREQ_100KHZ: low_fs = `BSC_FS_100PF;
                `BSC_FREQ_1MHZ: low_fs = `BSC_FS_1PF;
                default: low_fs = `BSC_FS_1PF;
            endcase
        end else begin
            low_fs = range_full_scale;
        end
        low_prod  = (low_fs * $signed({1'b0, low_pct})) / `BSC_PCT_SCALE;
        low_bound = low_prod[W-1:0];
        next_low  = low_enable && !meas_overload && (meas_primary <= low_bound);
    end

    ////////////////////////////////////////////////////////////////////////////
    // sorting judgment: lowest matching primary range wins
    always @* begin
        next_category = `BSC_CAT_REJECT;
        pri_pass      = 1'b0;
        for (i = `BSC_NUM_PRI - 1; i >= 0; i = i - 1) begin
            if (hit[i]) begin
                next_category = i[`BSC_CAT_W-1:0] + 4'h1;
                pri_pass      = 1'b1;
            end
        end
        // a secondary range with upper at or below lower counts as switched off
        if (pri_pass && range_on[NR-1] && (hi_mem[NR-1] > lo_mem[NR-1]) && !hit[NR-1]) begin
            next_category = aux_enable ? `BSC_CAT_AUX : `BSC_CAT_REJECT;
        end
        if (meas_overload) begin
            next_category = `BSC_CAT_OVERLOAD_RESULT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result registers, updated one cycle after the strobe; improper_limits follows the table every cycle
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            result_valid              <= 1'b0;
            category                  <= `BSC_CAT_REJECT;
            overload_result           <= 1'b0;
            low_value_indication      <= 1'b0;
            low_value_or_no_contact_n <= 1'b1;
            improper_limits           <= 1'b0;
        end else begin
            result_valid    <= meas_valid && comp_enable;
            improper_limits <= |bad;
            if (meas_valid && comp_enable) begin
                category                  <= next_category;
                overload_result           <= meas_overload;
                low_value_indication      <= next_low;
                low_value_or_no_contact_n <= ~next_low;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counting enable state
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            counting_active <= 1'b0;
        end else if (count_on_cmd) begin
            counting_active <= 1'b1;
        end else if (count_off_cmd) begin
            counting_active <= 1'b0;
        end
    end

    // active counter set: per channel only with per-channel correction
    always @* begin
        cnt_ch = multi_enable ? meas_channel : {CH_W{1'b0}};
        cidx   = cnt_ch * `BSC_NUM_CAT + next_category;
    end

    ////////////////////////////////////////////////////////////////////////////
    // category counters, overload included, saturating
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < NCNT; i = i + 1) begin
                cnt_mem[i] <= {`BSC_CNT_W{1'b0}};
            end
        end else if (count_reset_cmd) begin
            for (i = 0; i < NCNT; i = i + 1) begin
                cnt_mem[i] <= {`BSC_CNT_W{1'b0}};
            end
        end else if (meas_valid && comp_enable && counting_active && (cnt_ch < CHANNELS)) begin
            if (cnt_mem[cidx] != `BSC_CNT_MAX) begin
                cnt_mem[cidx] <= cnt_mem[cidx] + 20'h00001;
            end
        end
    end

    // counter read port, registered
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_rd_data <= {`BSC_CNT_W{1'b0}};
        end else if ((cnt_rd_channel < CHANNELS) && (cnt_rd_category < `BSC_NUM_CAT)) begin
            cnt_rd_data <= cnt_mem[cnt_rd_channel * `BSC_NUM_CAT + cnt_rd_category];
        end else begin
            cnt_rd_data <= {`BSC_CNT_W{1'b0}};
        end
    end
endmodule

// ### testbench/bsc_comparator_chk.sv
`timescale 1ns/1ps
`include "bsc_defines.vh"

// watches result, flag and counter ports of the comparator
module bsc_comparator_chk (
    input logic                  clk_sys,
    input logic                  rst_n,
    input logic                  comp_enable,
    input logic                  meas_valid,
    input logic                  meas_overload,
    input logic                  count_on_cmd,
    input logic                  count_off_cmd,
    input logic                  count_reset_cmd,
    input logic                  result_valid,
    input logic [`BSC_CAT_W-1:0] category,
    input logic                  overload_result,
    input logic                  low_value_indication,
    input logic                  low_value_or_no_contact_n,
    input logic                  counting_active,
    input logic [`BSC_CNT_W-1:0] cnt_rd_data
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // a measurement that the comparator accepts
    wire take = meas_valid & comp_enable;

    property p_resp; take |=> result_valid; endproperty
    a_resp: assert property (p_resp) else $error("missing result");
    property p_noresp; !take |=> !result_valid; endproperty
    a_noresp: assert property (p_noresp) else $error("spurious result");
    property p_overload_result; take && meas_overload |=> overload_result && category == `BSC_CAT_OVERLOAD_RESULT; endproperty
    a_overload_result: assert property (p_overload_result) else $error("overload not reported");
    property p_pin; result_valid |-> low_value_or_no_contact_n == !low_value_indication; endproperty
    a_pin: assert property (p_pin) else $error("low pin disagrees");
    property p_hold; !take |=> $stable(category) && $stable(overload_result); endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    property p_on; count_on_cmd |=> counting_active; endproperty
    a_on: assert property (p_on) else $error("count not on");
    property p_off; count_off_cmd && !count_on_cmd |=> !counting_active; endproperty
    a_off: assert property (p_off) else $error("count not off");
    property p_keep; !count_on_cmd && !count_off_cmd |=> $stable(counting_active); endproperty
    a_keep: assert property (p_keep) else $error("count state moved");
    property p_clr; count_reset_cmd |=> ##1 cnt_rd_data == 0; endproperty
    a_clr: assert property (p_clr) else $error("counter not cleared");
    property p_sat; cnt_rd_data <= `BSC_CNT_MAX; endproperty
    a_sat: assert property (p_sat) else $error("counter above max");
endmodule

bind bsc_comparator bsc_comparator_chk u_chk (.*);

// ### testbench/bsc_meas_src.sv
`timescale 1ns/1ps

// measurement engine: one valid strobe per finished measurement
module bsc_meas_src (
    input  logic        clk_sys,
    output logic        meas_valid,
    output logic [31:0] meas_primary,
    output logic [31:0] meas_secondary,
    output logic        meas_overload,
    output logic [1:0]  meas_channel
);
    initial begin
        {meas_valid, meas_primary, meas_secondary, meas_overload, meas_channel} = '0;
    end

    // data valid for one cycle, then lines show the inverse
    task send(input logic [31:0] p, s, input logic ov, input logic [1:0] c);
        @(negedge clk_sys);
        {meas_valid, meas_primary, meas_secondary, meas_overload, meas_channel} = {1'b1, p, s, ov, c};
        @(negedge clk_sys);
        {meas_valid, meas_primary, meas_secondary, meas_overload, meas_channel} = {1'b0, ~p, ~s, ~ov, ~c};
    endtask
endmodule

// ### testbench/bin_sorting_comparator_test.sv
`timescale 1ns/1ps
`include "bsc_defines.vh"

module bin_sorting_comparator_test;
    logic clk_sys, rst_n, lim_wr_lo, lim_wr_hi, lim_wr_on, lim_wr_off, lim_clear, table_clear, comp_enable;
    logic aux_enable, low_enable, auto_range, multi_enable, count_on_cmd, count_off_cmd, count_reset_cmd;
    logic meas_valid, meas_overload, result_valid, overload_result, low_value_indication;
    logic low_value_or_no_contact_n, improper_limits, counting_active;
    logic [1:0] mode, ch, cnt_rd_channel, meas_channel;
    logic [2:0] freq_sel;
    logic [3:0] lim_sel, cnt_rd_category, category;
    logic [15:0] low_pct;
    logic [19:0] cnt_rd_data;
    logic signed [31:0] lim_value, reference_value, range_full_scale, meas_primary, meas_secondary;
    int mlo[10], mhi[10], miscompares, cmp_count, cyc;
    bit mon[10];
    logic [31:0] seed = 32'h432D5D66;
    int edges[8] = '{-2000, -2001, 2000, 2001, 5000, 5001, -5000, -5001};

    bsc_comparator u_dut (.*);
    bsc_meas_src u_src (.clk_sys(clk_sys), .meas_valid(meas_valid), .meas_primary(meas_primary),
        .meas_secondary(meas_secondary), .meas_overload(meas_overload), .meas_channel(meas_channel));

    initial begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end

    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // expected category from the mirrored limit table
    function automatic logic [3:0] exp_cat(input int p, s, input logic ov);
        longint lo, hi;
        exp_cat = 4'h0;
        for (int i = 8; i >= 0; i--) begin
            lo = mlo[i];
            hi = mhi[i];
            if (mode == 1 || mode == 2) begin
                lo = mode == 1 ? reference_value + lo : reference_value + reference_value * lo / 10000;
                hi = mode == 1 ? reference_value + hi : reference_value + reference_value * hi / 10000;
            end
            if (mon[i] && hi > lo && p >= lo && p <= hi) exp_cat = 4'(i + 1);
        end
        if (exp_cat != 0 && mon[9] && mhi[9] > mlo[9] && (s < mlo[9] || s > mhi[9]))
            exp_cat = aux_enable ? 4'hA : 4'h0;
        if (ov) exp_cat = 4'hB;
    endfunction

    // expected low-value flag
    function automatic logic exp_low(input int p, input logic ov);
        longint fs;
        fs = !auto_range ? range_full_scale : freq_sel < 2 ? 10000000 : freq_sel < 5 ? 100000 : 1000;
        return low_enable && !ov && p <= fs * $signed({1'b0, low_pct}) / 10000;
    endfunction

    task bad(input string w);
        miscompares++;
        $display("BAD %0t %s", $time, w);
    endtask
    task chk_bit(input logic g, e);
        cmp_count++;
        if (g !== e) bad("flag");
    endtask
    task chk_cat(input logic [3:0] g, e);
        cmp_count++;
        if (g !== e) bad($sformatf("category %h not %h", g, e));
    endtask
    task chk_cnt(input logic [19:0] g, e);
        cmp_count++;
        if (g !== e) bad($sformatf("count %0d not %0d", g, e));
    endtask

    // limit entry: 0 lower, 1 upper, 2 on, 3 off, else clear
    task wr(input logic [3:0] sel, input int v, input int k);
        @(negedge clk_sys);
        lim_sel = sel;
        lim_value = v;
        {lim_wr_lo, lim_wr_hi, lim_wr_on, lim_wr_off, lim_clear} = 5'h10 >> (k > 4 ? 4 : k);
        @(negedge clk_sys);
        {lim_wr_lo, lim_wr_hi, lim_wr_on, lim_wr_off, lim_clear} = '0;
        if (sel < 10) case (k)
            0: {mlo[sel], mhi[sel]} = {v, v};
            1: {mlo[sel], mhi[sel]} = {-v, v};
            2: mon[sel] = 1;
            3: mon[sel] = 0;
            default: {mlo[sel], mhi[sel], mon[sel]} = '0;
        endcase
    endtask

    // counter command: 0 on, 1 off, 2 reset
    task cmd(input int k);
        @(negedge clk_sys);
        {count_on_cmd, count_off_cmd, count_reset_cmd} = 3'h4 >> k;
        @(negedge clk_sys);
        {count_on_cmd, count_off_cmd, count_reset_cmd} = '0;
    endtask

    task m(input int p, s, input logic ov);
        u_src.send(p, s, ov, ch);
        chk_bit(result_valid, 1'b1);
        chk_cat(category, exp_cat(p, s, ov));
        chk_bit(overload_result, ov);
        chk_bit(low_value_indication, exp_low(p, ov));
        chk_bit(low_value_or_no_contact_n, !exp_low(p, ov));
    endtask

    task rd(input logic [1:0] c, input logic [3:0] k, input logic [19:0] e);
        @(negedge clk_sys);
        {cnt_rd_channel, cnt_rd_category} = {c, k};
        @(negedge clk_sys);
        chk_cnt(cnt_rd_data, e);
    endtask

    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, lim_wr_lo, lim_wr_hi, lim_wr_on, lim_wr_off, lim_clear, table_clear, comp_enable, aux_enable} = '0;
        {low_enable, auto_range, multi_enable, count_on_cmd, count_off_cmd, count_reset_cmd} = '0;
        {mode, ch, cnt_rd_channel, freq_sel, lim_sel, cnt_rd_category, low_pct} = '0;
        {lim_value, reference_value, range_full_scale} = '0;
        repeat (6) @(negedge clk_sys);
        rst_n = 1;
        comp_enable = 1;
        multi_enable = 1;
        cmd(2);
        cmd(0);
        chk_bit(counting_active, 1'b1);
        ch = 1;
        m(0, 0, 1);
        m(0, 0, 1);
        ch = 0;
        m(5, 0, 0);
        rd(1, 11, 2);
        rd(0, 11, 0);
        rd(0, 0, 1);
        cmd(1);
        chk_bit(counting_active, 1'b0);
        ch = 1;
        m(0, 0, 1);
        rd(1, 11, 2);
        cmd(2);
        rd(1, 11, 0);
        rd(0, 0, 0);
        multi_enable = 0;
        wr(0, 1000, 0);
        wr(0, 0, 2);
        m(1000, 0, 0);
        wr(0, 2000, 1);
        wr(1, 5000, 1);
        wr(1, 0, 2);
        wr(12, 7, 0);
        m(100, 0, 0);
        m(3000, 0, 0);
        wr(2, -50, 1);
        wr(2, 0, 2);
        @(negedge clk_sys);
        chk_bit(improper_limits, 1'b1);
        wr(2, 0, 4);
        @(negedge clk_sys);
        chk_bit(improper_limits, 1'b0);
        wr(9, 100, 1);
        wr(9, 0, 2);
        m(100, 500, 0);
        aux_enable = 1;
        m(100, 500, 0);
        m(100, -100, 0);
        wr(9, 100, 0);
        m(100, 500, 0);
        wr(9, 100, 1);
        reference_value = 10000;
        for (int md = 0; md < 3; md++) begin
            mode = 2'(md);
            foreach (edges[j]) m((md > 0 ? 10000 : 0) + edges[j], 0, 0);
            repeat (40) begin
                seed = lfsr(seed);
                ch = seed[1:0];
                m(int'(seed % 32001) - 16000, int'(seed[15:8]) - 128, seed[20:16] == 0);
            end
        end
        mode = 0;
        low_enable = 1;
        range_full_scale = 200000;
        low_pct = 100;
        m(2000, 0, 0);
        m(2001, 0, 0);
        m(5, 0, 1);
        auto_range = 1;
        for (int f = 0; f < 6; f++) begin
            freq_sel = 3'(f);
            m(f < 2 ? 100000 : f < 5 ? 1000 : 10, 0, 0);
            m(f < 2 ? 100001 : f < 5 ? 1001 : 11, 0, 0);
        end
        comp_enable = 0;
        u_src.send(100, 0, 0, 0);
        chk_bit(result_valid, 1'b0);
        results();
    end
endmodule
